// ### shared/cnvp_pkg.sv
// Constants and types shared by the configuration non-volatile programming block.
`default_nettype none
package cnvp_pkg;
	// Serial slave address; the value is arbitrary.
	localparam logic [6:0] DEV_ADDR = 7'h10;
	// Register map.
	localparam logic [7:0] ADDR_CFG_FIRST = 8'h01;
	localparam logic [7:0] ADDR_CFG_LAST = 8'h0a;
	localparam logic [7:0] ADDR_BAL_CFG = 8'h0a;
	localparam logic [7:0] ADDR_KEY = 8'h0b;
	localparam int CFG_COUNT = 10;
	// Key values.
	localparam logic [7:0] KEY_WRITE = 8'h41;
	localparam logic [7:0] KEY_PREREAD = 8'h62;
	localparam logic [7:0] KEY_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// Synchroniser value after reset: {strobe, port enable, data, clock}, each at its idle level.
	localparam logic [3:0] PIN_IDLE = 4'h7;
	// Fields of the balance configuration register.
	localparam int BAL_EN_HI = 7;
	localparam int BAL_EN_LO = 6;
	localparam int BAL_THR_HI = 3;
	localparam int BAL_THR_LO = 0;
	// Threshold decode in millivolts: top setting and step per code.
	localparam logic [15:0] THR_TOP_MV = 16'h0f3c;
	localparam logic [15:0] THR_STEP_MV = 16'h0064;
	// Balance enable selections.
	typedef enum logic [1:0] {
		BAL_OFF = 2'b00,
		BAL_ALWAYS = 2'b01,
		BAL_CHARGER = 2'b10,
		BAL_CHARGER_TIMED = 2'b11
	} cnvp_bal_sel_t;
	// Serial slave states.
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ACK_A = 4'b0010,
		ST_REG = 4'b0011,
		ST_ACK_R = 4'b0100,
		ST_WR = 4'b0101,
		ST_ACK_W = 4'b0110,
		ST_RD = 4'b0111,
		ST_RACK = 4'b1000
	} cnvp_state_t;
endpackage
`default_nettype wire

// ### rtl/cnvp_top.sv
// Configuration storage, access key, programming strobe, parity guard and balance start.
//
// Functional notes
// (R1) Balancing starts when the highest cell reaches the programmed start threshold, if enabled.
// (R2) Charger-dependent enable settings also need a detected charger before balancing starts.
// (R3) Threshold code 0000 means 3.9 V, each step lowers 0.1 V, 1111 means 2.4 V.
// (R4) Key 0x41 enables writing configuration memory locations 0x01 to 0x0A.
// (R5) Key 0x62 makes a pre-read of stored memory contents available.
// (R6) Key register resets to 0x00, so writing and pre-read start disabled.
// (R7) Serial clock and data pins work only while the port enable pin is high.
// (R8) Host loads configuration registers first, then writes 0x41 to power programming.
// (R9) Strobe pin pulsed high then low commits configuration registers into memory.
// (R10) Memory holds protection thresholds, delays and trim data.
// (R11) Stored contents are protected by a column parity byte.
// (R12) Parity mismatch forces discharge and charge FET drives off.
// (R13) Balance start threshold sits in bits 3 to 0, sixteen settings.
// (R14) Balance enable field 00 keeps balancing disabled.
// (R15) Key values other than the two defined leave writing and pre-read disabled.
`default_nettype none
module cnvp_top (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Two-wire serial pins
	input wire logic scl_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic serial_port_enable_pin,
	input wire logic program_strobe_pin,
	// Cell monitor and FET requests
	input wire logic [15:0] max_cell_mv,
	input wire logic charger_present,
	input wire logic discharge_request,
	input wire logic charge_request,
	// Status and drives
	output logic balance_start,
	output logic discharge_fet_drive,
	output logic charge_fet_drive,
	output logic parity_fault,
	output logic programming_supply_on,
	output logic preread_active
);
	import cnvp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Functions.

	function automatic logic [7:0] col_parity(input logic [CFG_COUNT:1][7:0] mem);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 1; i <= CFG_COUNT; i++) begin
			p = p ^ mem[i];
		end
		return p;
	endfunction

	function automatic logic in_cfg(input logic [7:0] a);
		return (a >= ADDR_CFG_FIRST) && (a <= ADDR_CFG_LAST);
	endfunction

	function automatic logic [15:0] bal_threshold(input logic [3:0] code);
		return 16'(THR_TOP_MV - 16'(16'(code) * THR_STEP_MV));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the third stage only serves edge detection.

	logic [3:0] pin_s1_r, pin_s2_r, pin_s3_r;
	logic [3:0] pin_s1_nxt, pin_s2_nxt, pin_s3_nxt;

	always_comb begin
		pin_s1_nxt = {program_strobe_pin, serial_port_enable_pin, sda_in, scl_pin};
		pin_s2_nxt = pin_s1_r;
		pin_s3_nxt = pin_s2_r;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_s1_r <= PIN_IDLE;
			pin_s2_r <= PIN_IDLE;
			pin_s3_r <= PIN_IDLE;
		end else begin
			pin_s1_r <= pin_s1_nxt;
			pin_s2_r <= pin_s2_nxt;
			pin_s3_r <= pin_s3_nxt;
		end
	end

	logic scl, sda, port_en, scl_rise, scl_fall, start_seen, stop_seen, strobe_fall;
	assign scl = pin_s2_r[0];
	assign sda = pin_s2_r[1];
	assign port_en = pin_s2_r[2];
	assign scl_rise = scl && !pin_s3_r[0];
	assign scl_fall = !scl && pin_s3_r[0];
	assign start_seen = scl && pin_s3_r[0] && !sda && pin_s3_r[1];
	assign stop_seen = scl && pin_s3_r[0] && sda && !pin_s3_r[1];
	assign strobe_fall = !pin_s2_r[3] && pin_s3_r[3];

	////////////////////////////////////////////////////////////////////////////////
	// Register and memory state.

	logic [CFG_COUNT:1][7:0] cfg_r, cfg_nxt, nv_r, nv_nxt;
	logic [7:0] parity_r, parity_nxt, key_r, key_nxt;
	logic wr_en;
	logic [7:0] wr_addr, wr_data;
	logic key_write, key_preread;

	assign key_write = (key_r == KEY_WRITE); // [R4] [R15]
	assign key_preread = (key_r == KEY_PREREAD); // [R5] [R15]

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		if (in_cfg(a)) begin
			return key_preread ? nv_r[a[3:0]] : cfg_r[a[3:0]]; // [R5]
		end else if (a == ADDR_KEY) begin
			return key_r;
		end
		return 8'h00;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Serial slave.

	cnvp_state_t st_r, st_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt;
	logic rw_r, rw_nxt, done_r, done_nxt, oe_r, oe_nxt;

	always_comb begin
		logic [7:0] rd;
		rd = reg_read(ptr_r);
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		ptr_nxt = ptr_r;
		rw_nxt = rw_r;
		done_nxt = done_r;
		oe_nxt = oe_r;
		wr_en = 1'b0;
		wr_addr = ptr_r;
		wr_data = sh_r;
		if (!port_en) begin // [R7]
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
			done_nxt = 1'b0;
		end else if (start_seen) begin
			st_nxt = ST_ADDR;
			cnt_nxt = 3'h0;
			done_nxt = 1'b0;
			oe_nxt = 1'b0;
		end else if (stop_seen) begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
		end else begin
			case (st_r)
				ST_ADDR, ST_REG, ST_WR: begin
					if (scl_rise && !done_r) begin
						sh_nxt = {sh_r[6:0], sda};
						cnt_nxt = 3'(cnt_r + 3'h1);
						done_nxt = (cnt_r == 3'h7);
					end else if (scl_fall && done_r) begin
						done_nxt = 1'b0;
						cnt_nxt = 3'h0;
						oe_nxt = 1'b1;
						if (st_r == ST_ADDR) begin
							if (sh_r[7:1] == DEV_ADDR) begin
								rw_nxt = sh_r[0];
								st_nxt = ST_ACK_A;
							end else begin
								oe_nxt = 1'b0;
								st_nxt = ST_IDLE;
							end
						end else if (st_r == ST_REG) begin
							ptr_nxt = sh_r;
							st_nxt = ST_ACK_R;
						end else begin
							wr_en = 1'b1;
							ptr_nxt = 8'(ptr_r + 8'h01);
							st_nxt = ST_ACK_W;
						end
					end
				end
				ST_ACK_A, ST_RACK: begin
					if (st_r == ST_RACK && scl_rise && sda) begin
						st_nxt = ST_IDLE;
					end else if (scl_fall) begin
						if (rw_r) begin
							sh_nxt = rd;
							oe_nxt = !rd[7];
							cnt_nxt = 3'h0;
							ptr_nxt = 8'(ptr_r + 8'h01);
							st_nxt = ST_RD;
						end else begin
							oe_nxt = 1'b0;
							st_nxt = ST_REG;
						end
					end
				end
				ST_ACK_R, ST_ACK_W: begin
					if (scl_fall) begin
						oe_nxt = 1'b0;
						st_nxt = ST_WR;
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (cnt_r == 3'h7) begin
							oe_nxt = 1'b0;
							st_nxt = ST_RACK;
						end else begin
							sh_nxt = {sh_r[6:0], 1'b0};
							oe_nxt = !sh_r[6];
							cnt_nxt = 3'(cnt_r + 3'h1);
						end
					end
				end
				default: begin
					oe_nxt = 1'b0;
					st_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= ST_IDLE;
			cnt_r <= 3'h0;
			sh_r <= 8'h00;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			done_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			ptr_r <= ptr_nxt;
			rw_r <= rw_nxt;
			done_r <= done_nxt;
			oe_r <= oe_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers, key and non-volatile store.

	always_comb begin
		cfg_nxt = cfg_r;
		key_nxt = key_r;
		nv_nxt = nv_r;
		parity_nxt = parity_r;
		if (wr_en && in_cfg(wr_addr)) begin
			cfg_nxt[wr_addr[3:0]] = wr_data;
		end
		if (wr_en && wr_addr == ADDR_KEY) begin
			key_nxt = wr_data;
		end
		// The store takes the registers only while the write key powers programming.
		if (strobe_fall && key_write) begin // [R9] [R4] [R10]
			nv_nxt = cfg_r;
			parity_nxt = col_parity(cfg_r); // [R11]
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cfg_r <= {CFG_COUNT{CFG_RESET}};
			key_r <= KEY_RESET; // [R6]
			nv_r <= {CFG_COUNT{CFG_RESET}};
			parity_r <= 8'h00;
		end else begin
			cfg_r <= cfg_nxt;
			key_r <= key_nxt;
			nv_r <= nv_nxt;
			parity_r <= parity_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Balance start, parity guard and outputs.

	logic [7:0] bal_cfg;
	cnvp_bal_sel_t bal_sel;
	logic bal_nxt, fault_nxt, dsg_nxt, chg_nxt;
	logic bal_r, fault_r, dsg_r, chg_r, supply_r, preread_r, sda_out_r;

	assign bal_cfg = cfg_r[ADDR_BAL_CFG[3:0]];
	assign bal_sel = cnvp_bal_sel_t'(bal_cfg[BAL_EN_HI:BAL_EN_LO]);

	always_comb begin
		bal_nxt = (bal_sel != BAL_OFF) // [R14]
			&& (max_cell_mv >= bal_threshold(bal_cfg[BAL_THR_HI:BAL_THR_LO])) // [R1] [R3] [R13]
			&& (bal_sel == BAL_ALWAYS || charger_present); // [R2]
		fault_nxt = (col_parity(nv_r) != parity_r); // [R11]
		dsg_nxt = discharge_request && !fault_nxt; // [R12]
		chg_nxt = charge_request && !fault_nxt; // [R12]
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bal_r <= 1'b0;
			fault_r <= 1'b0;
			dsg_r <= 1'b0;
			chg_r <= 1'b0;
			supply_r <= 1'b0;
			preread_r <= 1'b0;
			sda_out_r <= 1'b0;
		end else begin
			bal_r <= bal_nxt;
			fault_r <= fault_nxt;
			dsg_r <= dsg_nxt;
			chg_r <= chg_nxt;
			supply_r <= key_write; // [R8]
			preread_r <= key_preread;
			sda_out_r <= 1'b0;
		end
	end

	assign sda_out = sda_out_r;
	assign sda_oe = oe_r;
	assign balance_start = bal_r;
	assign discharge_fet_drive = dsg_r;
	assign charge_fet_drive = chg_r;
	assign parity_fault = fault_r;
	assign programming_supply_on = supply_r;
	assign preread_active = preread_r;
endmodule
`default_nettype wire

// ### dv/cnvp_host.sv
// Two-wire host model that programs the configuration block.
`default_nettype none
module cnvp_host (
	// Clock
	input wire logic clock,
	// Bus lines
	input wire logic sda_w,
	output logic scl,
	output logic sda_lo
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sda_lo = 1'b0;
	end
	task automatic hw();
		repeat (6) @(posedge clock);
	endtask
	task automatic start();
		sda_lo <= 1'b1;
		hw();
		scl <= 1'b0;
		hw();
	endtask
	task automatic stop();
		sda_lo <= 1'b1;
		hw();
		scl <= 1'b1;
		hw();
		sda_lo <= 1'b0;
		hw();
	endtask
	// Eight data bits MSB first, then the ninth bit: last high releases the line.
	task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] d, output logic ack);
		logic s;
		for (int i = 8; i >= 0; i--) begin
			sda_lo <= (i > 0) ? !b[i-1] : !last;
			hw();
			scl <= 1'b1;
			hw();
			s = sda_w;
			if (i > 0) d[i-1] = s;
			scl <= 1'b0;
			hw();
		end
		ack = !s;
	endtask
endmodule
`default_nettype wire

// ### dv/cnvp_top_sva.sv
// Port checks for the configuration programming block.
`default_nettype none
module cnvp_top_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Inputs
	input wire logic scl_pin,
	input wire logic serial_port_enable_pin,
	input wire logic [15:0] max_cell_mv,
	input wire logic discharge_request,
	input wire logic charge_request,
	// Outputs
	input wire logic sda_oe,
	input wire logic balance_start,
	input wire logic discharge_fet_drive,
	input wire logic charge_fet_drive,
	input wire logic parity_fault,
	input wire logic programming_supply_on,
	input wire logic preread_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	chk_key_reset: assert property (disable iff (1'b0) !rst_n |=> !programming_supply_on && !preread_active)
		else $error("key state not clear");
	chk_key_exclusive: assert property (!(programming_supply_on && preread_active))
		else $error("both keys active");
	chk_dsg_gated: assert property (discharge_fet_drive |-> $past(discharge_request) && !parity_fault)
		else $error("discharge drive wrong");
	chk_chg_gated: assert property (charge_fet_drive |-> $past(charge_request) && !parity_fault)
		else $error("charge drive wrong");
	chk_port_off: assert property (!serial_port_enable_pin [*5] |-> !sda_oe)
		else $error("data driven while port off");
	chk_ack_timing: assert property ($rose(sda_oe) |-> !scl_pin && !$past(scl_pin, 2))
		else $error("data driven with clock high");
	chk_bal_floor: assert property (balance_start |-> $past(max_cell_mv) >= 16'h0960)
		else $error("balance below lowest threshold");
	chk_supply_port: assert property ($rose(programming_supply_on) |-> $past(serial_port_enable_pin, 3))
		else $error("supply on without port");
	cov_supply: cover property (programming_supply_on);
	cov_preread: cover property (preread_active);
	cov_balance: cover property ($rose(balance_start));
endmodule
`default_nettype wire

// ### dv/cnvp_top_tb_top.sv
// Self-checking bench for the configuration programming block.
`default_nettype none
module cnvp_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cnvp_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic serial_port_enable_pin = 1'b1;
	logic program_strobe_pin = 1'b0;
	logic [15:0] max_cell_mv = 16'h0000;
	logic charger_present = 1'b0;
	logic discharge_request = 1'b0;
	logic charge_request = 1'b0;
	logic probe = 1'b0;
	// Requests as the design sampled them one edge before a compare.
	logic [1:0] req_q = 2'b00;
	logic [7:0] rd;
	logic [8:0] n;
	logic [8:0] notes[$];
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed = 32'h51667132;
	wire scl, sda_lo, sda_oe, balance_start, discharge_fet_drive, charge_fet_drive;
	wire parity_fault, programming_supply_on, preread_active;
	// Open-drain data line with a pull-up.
	wire sda_w = !(sda_oe || sda_lo);
	always #12.5 clock = !clock;
	cnvp_host H (.clock, .sda_w, .scl, .sda_lo);
	cnvp_top DUT (.clock, .rst_n, .scl_pin(scl), .sda_in(sda_w), .sda_out(), .sda_oe,
		.serial_port_enable_pin, .program_strobe_pin, .max_cell_mv, .charger_present,
		.discharge_request, .charge_request, .balance_start, .discharge_fet_drive,
		.charge_fet_drive, .parity_fault, .programming_supply_on, .preread_active);
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	task automatic note(input logic [8:0] e);
		notes.push_back(e);
		probe <= 1'b1;
		@(posedge clock);
		probe <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] d;
		logic k;
		H.start();
		H.xfer({DEV_ADDR, 1'b0}, 1'b1, d, k);
		rd = {7'h00, k};
		H.xfer(a, 1'b1, d, k);
		H.xfer(v, 1'b1, d, k);
		H.stop();
	endtask
	task automatic rdreg(input logic [7:0] a);
		logic [7:0] d;
		logic k;
		// Pointer-only write, so the register read back is left untouched.
		H.start();
		H.xfer({DEV_ADDR, 1'b0}, 1'b1, d, k);
		H.xfer(a, 1'b1, d, k);
		H.stop();
		H.start();
		H.xfer({DEV_ADDR, 1'b1}, 1'b1, d, k);
		H.xfer(8'hff, 1'b1, rd, k);
		H.stop();
	endtask
	task automatic commit_with(input logic [7:0] k, input logic [7:0] st, input logic [7:0] e);
		wr(ADDR_KEY, k);
		note({1'b0, st});
		program_strobe_pin <= 1'b1;
		repeat (6) @(posedge clock);
		program_strobe_pin <= 1'b0;
		repeat (8) @(posedge clock);
		wr(ADDR_KEY, KEY_PREREAD);
		note(9'h004);
		rdreg(ADDR_CFG_FIRST);
		note({1'b1, e});
	endtask
	////////////////////////////////////////////////////////////////
	// Results are compared in order against the oldest pending note.
	always @(posedge clock) begin
		if (probe) begin
			n = notes.pop_front();
			if (n[8]) begin
				cmp("read byte", n[7:0], rd);
			end else begin
				cmp("status", n[7:0], {4'h0, programming_supply_on, preread_active, balance_start, parity_fault});
				cmp("fet drives", {6'h00, req_q}, {6'h00, discharge_fet_drive, charge_fet_drive});
			end
		end
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		{discharge_request, charge_request} <= 2'($random(seed));
		req_q <= {discharge_request, charge_request};
		if (cycles == 60000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		int r;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		note(9'h000);
		rdreg(ADDR_KEY);
		note({1'b1, KEY_RESET});
		rdreg(8'h0c);
		note(9'h100);
		for (int c = 0; c < 16; c++) begin
			wr(ADDR_BAL_CFG, {c[1:0], 2'b00, c[3:0]});
			for (int j = 0; j < 4; j++) begin
				r = {$random(seed)} % 100;
				charger_present <= j[1];
				max_cell_mv <= 16'(j[0] ? 3899 - 100 * c - r : 3900 - 100 * c + r);
				repeat (3) @(posedge clock);
				note({7'h00, c[1:0] != 2'b00 && !j[0] && (c[1:0] == 2'b01 || j[1]), 1'b0});
			end
		end
		wr(ADDR_CFG_FIRST, 8'h5a);
		commit_with(8'($random(seed)) | 8'h80, 8'h00, 8'h00);
		commit_with(KEY_WRITE, 8'h08, 8'h5a);
		serial_port_enable_pin <= 1'b0;
		repeat (8) @(posedge clock);
		wr(ADDR_KEY, KEY_WRITE);
		note(9'h100);
		note(9'h004);
		tally_and_finish();
	end
endmodule
bind cnvp_top cnvp_top_sva u_sva (.clock, .rst_n, .scl_pin, .serial_port_enable_pin, .max_cell_mv,
	.discharge_request, .charge_request, .sda_oe, .balance_start, .discharge_fet_drive,
	.charge_fet_drive, .parity_fault, .programming_supply_on, .preread_active);
`default_nettype wire
